// *** hw/boundary_scan_register_chain.sv ***
// boundary scan chain, test data registers and test port control
`timescale 1ns/10ps
`default_nettype none
`include "jtag_bsr_cfg.svh"

// Contract
// - bypass, boundary, identity share input and output
// - boundary chain selected by extest or sample
// - extest drives pins from update latches at once
// - cells latch on falling test clock edge
// - input pins observed only, never driven
// - enable cells hold update latch for driver
// - bidirectional pin uses enable and capture cell
// - enabled and no extest: capture core output
// - tri-stated or extest: capture pad input
// - pins get observe, control or both cells
// - sample on rising, change output on falling
// - reset by pin or five mode ones
// - extest code 000000, sample code 000001
module boundary_scan_register_chain #(
	parameter logic [31:0] ID_VALUE = 32'h1234_5001 // arbitrary value
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tck_pin,
	input wire logic tms_pin,
	input wire logic tdi_pin,
	input wire logic trst_n_pin,
	output logic tdo_pin,
	output logic tdo_oe,
	input wire logic [7:0] serial_rx_neg,
	input wire logic [7:0] serial_rx_pos,
	input wire logic [7:0] core_tx_data,
	output logic [7:0] serial_tx_data,
	input wire logic ref_clock_mode_select,
	input wire logic [3:0] master_mgmt_bus_addr_straps,
	input wire logic [3:0] slave_mgmt_bus_addr_straps,
	input wire logic auto_power_disable_n,
	input wire logic downstream_common_clock,
	input wire logic upstream_common_clock,
	input wire logic master_mgmt_bus_speed_sel,
	input wire logic fundamental_reset_n,
	input wire logic reset_halt_strap,
	input wire logic [15:0] core_bidi_out,
	input wire logic [15:0] core_bidi_oe,
	output logic [15:0] core_bidi_in,
	input wire logic [15:0] pad_bidi_in,
	output logic [15:0] pad_bidi_out,
	output logic [15:0] pad_bidi_oe
);
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [`SYNC_WIDTH-1:0] raw_in;
	logic [`SYNC_WIDTH-1:0] syn_in;
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic trst_n_s;
	logic [`OBS_CELLS-1:0] obs_s;
	logic [`BIDI_PINS-1:0] pad_in_s;

	// test port pins at bits 0 to 3, observed pins above them in chain order
	assign raw_in = {pad_bidi_in, reset_halt_strap, fundamental_reset_n,
		master_mgmt_bus_speed_sel, upstream_common_clock,
		downstream_common_clock, auto_power_disable_n,
		slave_mgmt_bus_addr_straps, master_mgmt_bus_addr_straps,
		ref_clock_mode_select, serial_rx_pos, serial_rx_neg,
		trst_n_pin, tdi_pin, tms_pin, tck_pin};

	bsr_sync2 #(
		.WIDTH(`SYNC_WIDTH)
	) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.async_in(raw_in),
		.sync_out(syn_in)
	);

	assign tck_s = syn_in[0];
	assign tms_s = syn_in[1];
	assign tdi_s = syn_in[2];
	assign trst_n_s = syn_in[3];
	assign obs_s = syn_in[4 +: `OBS_CELLS];
	assign pad_in_s = syn_in[4+`OBS_CELLS +: `BIDI_PINS];

	// ---------------------------------------------------------------
	// test clock edge detection
	// ---------------------------------------------------------------
	logic tck_d_ff;
	logic tck_rise;
	logic tck_fall;

	// previous synchronised test clock level
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			tck_d_ff <= 1'b0;
		else
			tck_d_ff <= tck_s;
	end

	assign tck_rise = tck_s && !tck_d_ff;
	assign tck_fall = !tck_s && tck_d_ff;

	// ---------------------------------------------------------------
	// scan state
	// ---------------------------------------------------------------
	jtag_bsr_pkg::tap_state_type state_ff;
	jtag_bsr_pkg::tap_state_type nxt_state_ff;
	logic [2:0] tms_cnt_ff;
	logic [2:0] nxt_tms_cnt_ff;
	logic [`IR_LEN-1:0] ir_sh_ff;
	logic [`IR_LEN-1:0] nxt_ir_sh_ff;
	logic [`IR_LEN-1:0] ir_ff;
	logic [`IR_LEN-1:0] nxt_ir_ff;
	logic bypass_ff;
	logic nxt_bypass_ff;
	logic [`ID_LEN-1:0] id_ff;
	logic [`ID_LEN-1:0] nxt_id_ff;
	logic [`CHAIN_LEN-1:0] chain_ff;
	logic [`CHAIN_LEN-1:0] nxt_chain_ff;
	logic [`CHAIN_LEN-1:0] upd_ff;
	logic [`CHAIN_LEN-1:0] nxt_upd_ff;
	logic [`CHAIN_LEN-1:0] cap_val;
	logic sel_bsr;
	logic sel_id;
	logic extest_on;
	logic apply_on;
	logic highz_on;
	logic ser_bit;
	logic shifting;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [0:0] fifo_out_data;

	// instruction decode
	assign extest_on = (ir_ff == `OP_EXTEST);
	assign sel_bsr = extest_on || (ir_ff == `OP_SAMPLE);
	assign sel_id = (ir_ff == `OP_IDCODE);
	assign apply_on = extest_on || (ir_ff == `OP_CLAMP);
	assign highz_on = (ir_ff == `OP_HIGHZ);
	assign shifting = (state_ff == jtag_bsr_pkg::shf_dr) ||
		(state_ff == jtag_bsr_pkg::shf_ir);

	// only the selected register reaches the shared output
	always_comb
	begin
		if (state_ff == jtag_bsr_pkg::shf_ir)
			ser_bit = ir_sh_ff[0];
		else if (sel_bsr)
			ser_bit = chain_ff[0];
		else if (sel_id)
			ser_bit = id_ff[0];
		else
			ser_bit = bypass_ff;
	end

	// capture values: observe cells, tx control cells, bidi pairs
	assign cap_val[`OBS_BASE +: `OBS_CELLS] = obs_s;
	assign cap_val[`TX_BASE +: `TX_CELLS] = core_tx_data;

	genvar gi;
	generate
		for (gi = 0; gi < `BIDI_PINS; gi = gi + 1)
		begin : g_bidi
			// enable cell then one capture register per pin
			assign cap_val[`BIDI_BASE+2*gi] = core_bidi_oe[gi];
			assign cap_val[`BIDI_BASE+2*gi+1] =
				(!extest_on && core_bidi_oe[gi]) ? core_bidi_out[gi]
				: pad_in_s[gi];
		end
	endgenerate

	// next values of tap, instruction and data registers
	always_comb
	begin
		nxt_state_ff = state_ff;
		nxt_tms_cnt_ff = tms_cnt_ff;
		nxt_ir_sh_ff = ir_sh_ff;
		nxt_ir_ff = ir_ff;
		nxt_bypass_ff = bypass_ff;
		nxt_id_ff = id_ff;
		nxt_chain_ff = chain_ff;
		nxt_upd_ff = upd_ff;
		if (tck_rise && fifo_in_ready)
		begin
			// sample mode select and data on the rising edge
			if (!tms_s)
				nxt_tms_cnt_ff = 3'h0;
			else if (tms_cnt_ff != `TLR_TMS_COUNT)
				nxt_tms_cnt_ff = tms_cnt_ff + 3'h1;
			case (state_ff)
				jtag_bsr_pkg::tlr:
					nxt_state_ff = tms_s ? jtag_bsr_pkg::tlr
						: jtag_bsr_pkg::rti;
				jtag_bsr_pkg::rti:
					nxt_state_ff = tms_s ? jtag_bsr_pkg::sel_dr
						: jtag_bsr_pkg::rti;
				jtag_bsr_pkg::sel_dr:
					nxt_state_ff = tms_s ? jtag_bsr_pkg::sel_ir
						: jtag_bsr_pkg::cap_dr;
				jtag_bsr_pkg::cap_dr:
				begin
					nxt_state_ff = tms_s ? jtag_bsr_pkg::ex1_dr
						: jtag_bsr_pkg::shf_dr;
					nxt_bypass_ff = 1'b0;
					nxt_id_ff = ID_VALUE;
					if (sel_bsr)
						nxt_chain_ff = cap_val;
				end
				jtag_bsr_pkg::shf_dr:
				begin
					nxt_state_ff = tms_s ? jtag_bsr_pkg::ex1_dr
						: jtag_bsr_pkg::shf_dr;
					if (sel_bsr)
						nxt_chain_ff = {tdi_s, chain_ff[`CHAIN_LEN-1:1]};
					else if (sel_id)
						nxt_id_ff = {tdi_s, id_ff[`ID_LEN-1:1]};
					else
						nxt_bypass_ff = tdi_s;
				end
				jtag_bsr_pkg::ex1_dr:
					nxt_state_ff = tms_s ? jtag_bsr_pkg::upd_dr
						: jtag_bsr_pkg::pau_dr;
				jtag_bsr_pkg::pau_dr:
					nxt_state_ff = tms_s ? jtag_bsr_pkg::ex2_dr
						: jtag_bsr_pkg::pau_dr;
				jtag_bsr_pkg::ex2_dr:
					nxt_state_ff = tms_s ? jtag_bsr_pkg::upd_dr
						: jtag_bsr_pkg::shf_dr;
				jtag_bsr_pkg::upd_dr:
					nxt_state_ff = tms_s ? jtag_bsr_pkg::sel_dr
						: jtag_bsr_pkg::rti;
				jtag_bsr_pkg::sel_ir:
					nxt_state_ff = tms_s ? jtag_bsr_pkg::tlr
						: jtag_bsr_pkg::cap_ir;
				jtag_bsr_pkg::cap_ir:
				begin
					nxt_state_ff = tms_s ? jtag_bsr_pkg::ex1_ir
						: jtag_bsr_pkg::shf_ir;
					nxt_ir_sh_ff = `IR_CAPTURE;
				end
				jtag_bsr_pkg::shf_ir:
				begin
					nxt_state_ff = tms_s ? jtag_bsr_pkg::ex1_ir
						: jtag_bsr_pkg::shf_ir;
					nxt_ir_sh_ff = {tdi_s, ir_sh_ff[`IR_LEN-1:1]};
				end
				jtag_bsr_pkg::ex1_ir:
					nxt_state_ff = tms_s ? jtag_bsr_pkg::upd_ir
						: jtag_bsr_pkg::pau_ir;
				jtag_bsr_pkg::pau_ir:
					nxt_state_ff = tms_s ? jtag_bsr_pkg::ex2_ir
						: jtag_bsr_pkg::pau_ir;
				jtag_bsr_pkg::ex2_ir:
					nxt_state_ff = tms_s ? jtag_bsr_pkg::upd_ir
						: jtag_bsr_pkg::shf_ir;
				jtag_bsr_pkg::upd_ir:
					nxt_state_ff = tms_s ? jtag_bsr_pkg::sel_dr
						: jtag_bsr_pkg::rti;
				default:
					nxt_state_ff = jtag_bsr_pkg::tlr;
			endcase
			// fifth consecutive one forces test-logic-reset
			if (tms_s && (tms_cnt_ff == `TLR_TMS_COUNT - 3'h1))
				nxt_state_ff = jtag_bsr_pkg::tlr;
		end
		if (tck_fall)
		begin
			// update latches load on the falling edge
			if (state_ff == jtag_bsr_pkg::upd_dr && sel_bsr)
				nxt_upd_ff = chain_ff;
			if (state_ff == jtag_bsr_pkg::upd_ir)
				nxt_ir_ff = ir_sh_ff;
			if (state_ff == jtag_bsr_pkg::tlr)
				nxt_ir_ff = `OP_IDCODE;
		end
		if (!trst_n_s)
		begin
			nxt_state_ff = jtag_bsr_pkg::tlr;
			nxt_tms_cnt_ff = 3'h0;
			nxt_ir_ff = `OP_IDCODE;
		end
	end

	// scan state registers
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			state_ff <= jtag_bsr_pkg::tlr;
			tms_cnt_ff <= 3'h0;
			ir_sh_ff <= `IR_CAPTURE;
			ir_ff <= `OP_IDCODE;
			bypass_ff <= 1'b0;
			id_ff <= '0;
			chain_ff <= '0;
			upd_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state_ff;
			tms_cnt_ff <= nxt_tms_cnt_ff;
			ir_sh_ff <= nxt_ir_sh_ff;
			ir_ff <= nxt_ir_ff;
			bypass_ff <= nxt_bypass_ff;
			id_ff <= nxt_id_ff;
			chain_ff <= nxt_chain_ff;
			upd_ff <= nxt_upd_ff;
		end
	end

	// ---------------------------------------------------------------
	// serial output path
	// ---------------------------------------------------------------
	logic tdo_ff;
	logic nxt_tdo_ff;
	logic tdo_oe_ff;
	logic nxt_tdo_oe_ff;
	logic fifo_pop;

	// bits leave only while the test clock is sampled low
	assign fifo_pop = fifo_out_valid && !tck_s;

	bsr_fifo #(
		.WIDTH(`TDO_FIFO_WIDTH),
		.DEPTH(`TDO_FIFO_DEPTH)
	) u_tdo_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(tck_fall && shifting),
		.in_ready(fifo_in_ready),
		.in_data(ser_bit),
		.out_valid(fifo_out_valid),
		.out_ready(!tck_s),
		.out_data(fifo_out_data)
	);

	// output and its enable change after the falling edge
	always_comb
	begin
		nxt_tdo_ff = fifo_pop ? fifo_out_data[0] : tdo_ff;
		nxt_tdo_oe_ff = tdo_oe_ff;
		if (tck_fall)
			nxt_tdo_oe_ff = shifting;
		if (!trst_n_s)
			nxt_tdo_oe_ff = 1'b0;
	end

	// serial output registers
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			tdo_ff <= 1'b0;
			tdo_oe_ff <= 1'b0;
		end
		else
		begin
			tdo_ff <= nxt_tdo_ff;
			tdo_oe_ff <= nxt_tdo_oe_ff;
		end
	end

	assign tdo_pin = tdo_ff;
	assign tdo_oe = tdo_oe_ff;

	// ---------------------------------------------------------------
	// pad drive
	// ---------------------------------------------------------------
	logic [7:0] tx_ff;
	logic [7:0] nxt_tx_ff;
	logic [15:0] bo_ff;
	logic [15:0] nxt_bo_ff;
	logic [15:0] boe_ff;
	logic [15:0] nxt_boe_ff;
	logic [15:0] bin_ff;
	logic [15:0] nxt_bin_ff;

	// pins follow the core unless a test instruction holds them
	always_comb
	begin
		nxt_bin_ff = pad_in_s;
		nxt_tx_ff = apply_on ? upd_ff[`TX_BASE +: `TX_CELLS]
			: core_tx_data;
		for (int i = 0; i < `BIDI_PINS; i++)
		begin
			nxt_bo_ff[i] = apply_on ? upd_ff[`BIDI_BASE+2*i+1]
				: core_bidi_out[i];
			nxt_boe_ff[i] = apply_on ? upd_ff[`BIDI_BASE+2*i]
				: core_bidi_oe[i];
		end
		if (highz_on)
			nxt_boe_ff = '0;
	end

	// pad registers
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			tx_ff <= '0;
			bo_ff <= '0;
			boe_ff <= '0;
			bin_ff <= '0;
		end
		else
		begin
			tx_ff <= nxt_tx_ff;
			bo_ff <= nxt_bo_ff;
			boe_ff <= nxt_boe_ff;
			bin_ff <= nxt_bin_ff;
		end
	end

	assign serial_tx_data = tx_ff;
	assign pad_bidi_out = bo_ff;
	assign pad_bidi_oe = boe_ff;
	assign core_bidi_in = bin_ff;
endmodule
`default_nettype wire

// *** common/jtag_bsr_cfg.svh ***
// constants of the boundary scan chain and its test port
`ifndef JTAG_BSR_CFG_SVH
`define JTAG_BSR_CFG_SVH

// ---------------------------------------------------------------
// instruction register
// ---------------------------------------------------------------
`define IR_LEN 6
`define OP_EXTEST 6'h00
`define OP_SAMPLE 6'h01
`define OP_IDCODE 6'h02
`define OP_HIGHZ 6'h03
`define OP_CLAMP 6'h3E
`define OP_BYPASS 6'h3F
`define IR_CAPTURE 6'h2D

// ---------------------------------------------------------------
// mode select ones that force test-logic-reset
// ---------------------------------------------------------------
`define TLR_TMS_COUNT 3'h5

// ---------------------------------------------------------------
// chain layout, bit 0 nearest the serial output
// ---------------------------------------------------------------
`define OBS_CELLS 31
`define TX_CELLS 8
`define BIDI_PINS 16
`define OBS_BASE 0
`define TX_BASE 31
`define BIDI_BASE 39
`define CHAIN_LEN 71
`define ID_LEN 32

// ---------------------------------------------------------------
// buffering and synchroniser
// ---------------------------------------------------------------
`define TDO_FIFO_DEPTH 8
`define TDO_FIFO_WIDTH 1
`define SYNC_WIDTH 51

`endif

// *** common/jtag_bsr_pkg.sv ***
// types of the boundary scan chain and its test port
package jtag_bsr_pkg;

	// one-hot test access port states
	typedef enum logic [15:0] {
		tlr = 16'h0001,
		rti = 16'h0002,
		sel_dr = 16'h0004,
		cap_dr = 16'h0008,
		shf_dr = 16'h0010,
		ex1_dr = 16'h0020,
		pau_dr = 16'h0040,
		ex2_dr = 16'h0080,
		upd_dr = 16'h0100,
		sel_ir = 16'h0200,
		cap_ir = 16'h0400,
		shf_ir = 16'h0800,
		ex1_ir = 16'h1000,
		pau_ir = 16'h2000,
		ex2_ir = 16'h4000,
		upd_ir = 16'h8000
	} tap_state_type;

endpackage

// *** hw/bsr_sync2.sv ***
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module bsr_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// first stage is read by the second stage only
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule
`default_nettype wire

// *** hw/bsr_fifo.sv ***
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module bsr_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;
	logic push;
	logic pop;

	// full and empty come straight from the fill count
	assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem_ff[rd_ff];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage is written only, never reset
	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem_ff[wr_ff] <= in_data;
	end

	// pointers wrap at the depth
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end
		else
		begin
			if (push)
				wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
			if (pop)
				rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
			if (push && !pop)
				cnt_ff <= cnt_ff + 1'b1;
			else if (pop && !push)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule
`default_nettype wire

// *** verification/bsr_chain_chk.sv ***
// port assertions of the boundary scan chain
`timescale 1ns/10ps
`default_nettype none
module bsr_chain_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tck_pin,
	input wire logic trst_n_pin,
	input wire logic tdo_pin,
	input wire logic tdo_oe,
	input wire logic [7:0] core_tx_data,
	input wire logic [7:0] serial_tx_data,
	input wire logic [15:0] core_bidi_out,
	input wire logic [15:0] core_bidi_oe,
	input wire logic [15:0] core_bidi_in,
	input wire logic [15:0] pad_bidi_in,
	input wire logic [15:0] pad_bidi_out,
	input wire logic [15:0] pad_bidi_oe
);
	logic [2:0] warm_ff;
	logic [2:0] nxt_warm;
	// -------------------------------------------------------------
	// cycles since reset release, so history is clean
	// -------------------------------------------------------------
	always_comb
	begin
		nxt_warm = (warm_ff == 3'h4) ? warm_ff : warm_ff + 3'h1;
		if (!rst_n)
			nxt_warm = 3'h0;
	end
	always_ff @(posedge clk_sys)
	begin
		warm_ff <= nxt_warm;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n || warm_ff != 3'h4);
	// -------------------------------------------------------------
	// properties
	// -------------------------------------------------------------
	property p_trst_oe;
		!trst_n_pin [*4] |-> !tdo_oe;
	endproperty
	property p_tdo_fall;
		$changed(tdo_pin) |-> !tck_pin;
	endproperty
	property p_oe_fall;
		$changed(tdo_oe) |-> !tck_pin;
	endproperty
	property p_rise_quiet;
		$rose(tck_pin) |=> $stable(tdo_pin) [*8];
	endproperty
	property p_core_path;
		core_bidi_in == $past(pad_bidi_in, 3);
	endproperty
	property p_tx_cause;
		$changed(serial_tx_data) |->
			!tck_pin || $past(core_tx_data) != $past(core_tx_data, 2);
	endproperty
	property p_oe_cause;
		$changed(pad_bidi_oe) |->
			!tck_pin || $past(core_bidi_oe) != $past(core_bidi_oe, 2);
	endproperty
	property p_out_cause;
		$changed(pad_bidi_out) |->
			!tck_pin || $past(core_bidi_out) != $past(core_bidi_out, 2);
	endproperty
	a_trst_oe: assert property (p_trst_oe)
		else $error("tdo enable high in test reset");
	a_tdo_fall: assert property (p_tdo_fall)
		else $error("tdo moved while test clock high");
	a_oe_fall: assert property (p_oe_fall)
		else $error("tdo enable moved while test clock high");
	a_rise_quiet: assert property (p_rise_quiet)
		else $error("tdo moved after test clock rise");
	a_core_path: assert property (p_core_path)
		else $error("pad to core path disturbed");
	a_tx_cause: assert property (p_tx_cause)
		else $error("tx drive moved without cause");
	a_oe_cause: assert property (p_oe_cause)
		else $error("pad enable moved without cause");
	a_out_cause: assert property (p_out_cause)
		else $error("pad data moved without cause");
	// scenarios reached
	c_shift: cover property ($rose(tdo_oe));
	c_update: cover property ($changed(pad_bidi_oe) && !tck_pin);
	c_trst: cover property (!trst_n_pin);
endmodule
bind boundary_scan_register_chain bsr_chain_chk bsr_chain_chk_i (
	.clk_sys(clk_sys), .rst_n(rst_n), .tck_pin(tck_pin),
	.trst_n_pin(trst_n_pin), .tdo_pin(tdo_pin), .tdo_oe(tdo_oe),
	.core_tx_data(core_tx_data), .serial_tx_data(serial_tx_data),
	.core_bidi_out(core_bidi_out), .core_bidi_oe(core_bidi_oe),
	.core_bidi_in(core_bidi_in), .pad_bidi_in(pad_bidi_in),
	.pad_bidi_out(pad_bidi_out), .pad_bidi_oe(pad_bidi_oe)
);
`default_nettype wire

// *** verification/jtag_ctl_model.sv ***
// model of the external controller on the test port
`timescale 1ns/10ps
`default_nettype none
module jtag_ctl_model (
	output logic tck_pin,
	output logic tms_pin,
	output logic tdi_pin,
	output logic trst_n_pin,
	input wire logic tdo_pin,
	output logic [70:0] rx_vec,
	output logic rx_evt = 1'b0
);
	logic seen;
	// test clock stands low between frames, lines at pull-up level
	initial
	begin
		tck_pin = 1'b0;
		tms_pin = 1'b1;
		tdi_pin = 1'b1;
		trst_n_pin = 1'b1;
		rx_vec = 71'h0;
	end
	// one cycle: change after the fall, sample at the rise
	task automatic step(input logic m, input logic d);
	begin
		tms_pin = m;
		tdi_pin = d;
		#80 tck_pin = 1'b1;
		seen = tdo_pin;
		#80 tck_pin = 1'b0;
	end
	endtask
	// five ones reset the port, then a zero for idle
	task automatic go_idle;
	begin
		#1.7;
		repeat (5) step(1'b1, 1'b1);
		step(1'b0, 1'b1);
	end
	endtask
	// test reset pin held low for a while
	task automatic hold_reset;
	begin
		trst_n_pin = 1'b0;
		#200 trst_n_pin = 1'b1;
	end
	endtask
	// instruction or data scan from idle, result posted at the end
	task automatic scan(input logic ir, input int n, input logic [70:0] din);
		logic [70:0] got;
	begin
		got = 71'h0;
		#1.7;
		step(1'b1, 1'b1);
		if (ir)
			step(1'b1, 1'b1);
		step(1'b0, 1'b1);
		step(1'b0, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i]);
			got[i] = seen;
		end
		step(1'b1, 1'b1);
		step(1'b0, 1'b1);
		tdi_pin = 1'b1;
		rx_vec = got;
		rx_evt = !rx_evt;
	end
	endtask
endmodule
`default_nettype wire

// *** verification/test_boundary_scan_register_chain.sv ***
// self-checking bench of the boundary scan chain
`timescale 1ns/10ps
`default_nettype none
`include "jtag_bsr_cfg.svh"
module test_boundary_scan_register_chain;
	typedef struct packed {logic [70:0] v; logic [70:0] m;} note_type;
	localparam logic [31:0] ID = 32'h5A0F_3C21; // arbitrary value
	localparam logic [70:0] CM = {71{1'b1}};
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic tck, tms, tdi, trst_n, tdo, tdo_oe, rx_evt, pad_evt = 1'b0;
	logic [70:0] rx_vec, p, p_old;
	logic [30:0] obs = 31'h0;
	logic [7:0] core_tx = 8'h0, serial_tx, d;
	logic [15:0] bout = 16'h0, boe = 16'h0, pin = 16'h0, cin, pout, poe;
	note_type q[$];
	integer seed = 25318;
	int bad_count = 0;
	int total_checks = 0;
	always #2 clk_sys = ~clk_sys;
	boundary_scan_register_chain #(.ID_VALUE(ID))
	boundary_scan_register_chain_i (
		.clk_sys(clk_sys), .rst_n(rst_n), .tck_pin(tck), .tms_pin(tms),
		.tdi_pin(tdi), .trst_n_pin(trst_n), .tdo_pin(tdo), .tdo_oe(tdo_oe),
		.serial_rx_neg(obs[7:0]), .serial_rx_pos(obs[15:8]),
		.ref_clock_mode_select(obs[16]),
		.master_mgmt_bus_addr_straps(obs[20:17]),
		.slave_mgmt_bus_addr_straps(obs[24:21]),
		.auto_power_disable_n(obs[25]), .downstream_common_clock(obs[26]),
		.upstream_common_clock(obs[27]),
		.master_mgmt_bus_speed_sel(obs[28]),
		.fundamental_reset_n(obs[29]), .reset_halt_strap(obs[30]),
		.core_tx_data(core_tx), .serial_tx_data(serial_tx),
		.core_bidi_out(bout), .core_bidi_oe(boe), .core_bidi_in(cin),
		.pad_bidi_in(pin), .pad_bidi_out(pout), .pad_bidi_oe(poe)
	);
	jtag_ctl_model ctl_i (
		.tck_pin(tck), .tms_pin(tms), .tdi_pin(tdi), .trst_n_pin(trst_n),
		.tdo_pin(tdo), .rx_vec(rx_vec), .rx_evt(rx_evt)
	);
	// -------------------------------------------------------------
	// notes, comparison and verdict
	// -------------------------------------------------------------
	task automatic check(input string s, input logic [70:0] e,
		input logic [70:0] m, input logic [70:0] g);
	begin
		total_checks++;
		if ((g & m) !== (e & m))
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", s, e & m, g & m);
		end
	end
	endtask
	task automatic note(input logic [70:0] v, input logic [70:0] m);
	begin
		q.push_back({v, m});
	end
	endtask
	task automatic print_verdict;
	begin
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	// oldest note against a result; a result without a note fails
	task automatic take(input string s, input logic [70:0] g);
		note_type n;
	begin
		n = {{71{1'bx}}, {71{1'b1}}};
		if (q.size() != 0)
			n = q.pop_front();
		check(s, n.v, n.m, g);
	end
	endtask
	// monitors take the oldest note as each result appears
	always @(rx_evt)
		take("tdo", rx_vec);
	always @(pad_evt)
		take("pads", {31'h0, pout, poe, serial_tx});
	// -------------------------------------------------------------
	// stimulus helpers
	// -------------------------------------------------------------
	function automatic logic [70:0] cap(input logic ext);
		logic [70:0] v;
	begin
		v = {32'h0, core_tx, obs};
		for (int i = 0; i < 16; i++)
		begin
			v[39 + 2 * i] = boe[i];
			v[40 + 2 * i] = (!ext && boe[i]) ? bout[i] : pin[i];
		end
		return v;
	end
	endfunction
	function automatic logic [39:0] padx(input logic [70:0] l);
		logic [39:0] v;
	begin
		v = {32'h0, l[38:31]};
		for (int i = 0; i < 16; i++)
		begin
			v[8 + i] = l[39 + 2 * i];
			v[24 + i] = l[40 + 2 * i];
		end
		return v;
	end
	endfunction
	task automatic pads(input logic [39:0] v);
	begin
		repeat (3) @(posedge clk_sys);
		note({31'h0, v}, {31'h0, 40'hFF_FFFF_FFFF});
		#1 pad_evt = !pad_evt;
	end
	endtask
	task automatic shake;
	begin
		@(posedge clk_sys);
		obs <= 31'($random(seed));
		core_tx <= 8'($random(seed));
		bout <= 16'($random(seed));
		boe <= 16'($random(seed));
		pin <= 16'($random(seed));
		p = 71'({$random(seed), $random(seed), $random(seed)});
		repeat (4) @(posedge clk_sys);
	end
	endtask
	task automatic ir(input logic [5:0] op);
	begin
		note(71'h2D, 71'h3F);
		ctl_i.scan(1'b1, 6, {65'h0, op});
	end
	endtask
	task automatic idchk;
	begin
		note({39'h0, ID}, {39'h0, 32'hFFFF_FFFF});
		ctl_i.scan(1'b0, 32, 71'h0);
	end
	endtask
	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk_sys);
		ctl_i.go_idle();
		idchk(); // identity after reset
		$display("test identity done");
		repeat (3)
		begin
			shake();
			ir(`OP_SAMPLE); // sample code
			note(cap(1'b0), CM); // chain capture
			ctl_i.scan(1'b0, 71, p);
			pads({bout, boe, core_tx}); // pins untouched by sampling
		end
		$display("test sample done");
		ir(`OP_EXTEST); // after preload
		pads(padx(p)); // latches drive at once
		p_old = p;
		shake();
		pads(padx(p_old)); // held while core moves
		note(cap(1'b1), CM); // pad input captured
		ctl_i.scan(1'b0, 71, p);
		pads(padx(p)); // update drives pins
		ctl_i.hold_reset();
		ctl_i.go_idle();
		pads({bout, boe, core_tx}); // test reset frees pins
		idchk(); // identity after test reset
		$display("test extest done");
		ir(`OP_BYPASS);
		d = 8'($random(seed));
		note({63'h0, d[6:0], 1'b0}, 71'hFF); // one stage path
		ctl_i.scan(1'b0, 8, {63'h0, d});
		ir(`OP_HIGHZ);
		pads({bout, 16'h0, core_tx}); // enables forced off
		ir(`OP_CLAMP);
		pads(padx(p)); // latches held on pins
		ctl_i.go_idle();
		idchk(); // identity after five ones
		$display("test bypass done");
		note({7'h0, p[31:0], ID}, {7'h0, {64{1'b1}}});
		ctl_i.scan(1'b0, 64, {39'h0, p[31:0]});
		@(posedge clk_sys);
		#1 check("tdo enable", 71'h0, 71'h1, 71'(tdo_oe));
		check("tdo hold", 71'(p[31]), 71'h1, 71'(tdo));
		check("core in", 71'(pin), 71'hFFFF, 71'(cin));
		check("notes left", 71'h0, 71'hFF, 71'(q.size()));
		$display("test serial path done");
		print_verdict();
	end
	// hang guard
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		bad_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
